// file: rtl/dsr_err_fifo.sv
// Queue of receive error flags that travels alongside one channel's receive FIFO.
`timescale 1ns/1ps
module dsr_err_fifo
  import dsr_pkg::*;
#(
  parameter int DEPTH = RX_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [2:0] push_flags,
  input wire logic pop,
  input wire logic err_reset,
  input wire logic rx_reset,
  input wire logic block_mode,
  output logic [2:0] top_flags,
  output logic full,
  output logic not_empty
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("dsr_err_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][2:0] flags;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] cnt;
    logic [2:0] acc;
  } dsr_ef_state_t;

  dsr_ef_state_t s_reg;
  dsr_ef_state_t s_next;
  logic do_pop;
  logic do_push;
  logic [2:0] arriving;
  logic [PW-1:0] rptr_inc;

  always_comb begin
    s_next = s_reg;
    do_pop = pop && (s_reg.cnt != '0);
    do_push = push && ((s_reg.cnt != CW'(DEPTH)) || do_pop);
    rptr_inc = s_reg.rptr + 1'b1;
    arriving = 3'h0;
    if (do_push && ((s_reg.cnt == '0) || (do_pop && s_reg.cnt == CW'(1)))) begin
      arriving = push_flags;
    end else if (do_pop && s_reg.cnt > CW'(1)) begin
      arriving = s_reg.flags[rptr_inc];
    end
    if (err_reset || rx_reset) begin
      s_next.flags = '0;
      s_next.acc = 3'h0;
    end
    if (rx_reset) begin
      s_next.wptr = '0;
      s_next.rptr = '0;
      s_next.cnt = '0;
    end else begin
      if (do_pop) begin
        s_next.flags[s_reg.rptr] = 3'h0;
        s_next.rptr = rptr_inc;
      end
      if (do_push) begin
        s_next.flags[s_reg.wptr] = push_flags;
        s_next.wptr = s_reg.wptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        s_next.cnt = s_reg.cnt - 1'b1;
      end
      // A flag that reaches the top in the clearing cycle is kept.
      s_next.acc = s_next.acc | arriving;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign top_flags = block_mode ? s_reg.acc : s_reg.flags[s_reg.rptr];
  assign full = (s_reg.cnt == CW'(DEPTH));
  assign not_empty = (s_reg.cnt != '0);
endmodule // dsr_err_fifo

// file: rtl/dsr_pkg.sv
// Shared constants for the status, interrupt and output-port register bank.
package dsr_pkg;
  // Byte addresses of the word-aligned registers.
  localparam logic [7:0] ADDR_CHAN_A_LINE_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CHAN_B_LINE_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OUTPUT_PIN_SOURCE_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_OUTPUT_PIN_LATCH = 8'h0C;
  localparam logic [7:0] ADDR_AUXILIARY_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_INPUT_CHANGE_STATUS = 8'h14;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_INTERRUPT_MASK = 8'h1C;
  localparam logic [7:0] ADDR_TIMER_PRESET_UPPER = 8'h20;
  localparam logic [7:0] ADDR_TIMER_PRESET_LOWER = 8'h24;
  localparam logic [7:0] ADDR_ERROR_RESET_CMD = 8'h28;

  // Reset value of every writable register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions.
  localparam int AUX_BAUD_SET_BIT = 7;
  localparam int AUX_CT_MODE_LSB = 4;
  localparam int OCFG_PIN3_LSB = 2;
  localparam int OCFG_PIN2_LSB = 0;
  localparam int CMD_ERR_RESET_LSB = 0;

  // Pin 3 and pin 2 source selections.
  localparam logic [1:0] SRC_LATCH = 2'h0;
  localparam logic [1:0] SRC_ALT1 = 2'h1;
  localparam logic [1:0] SRC_ALT2 = 2'h2;

  // Receive FIFO depth.
  localparam int RX_FIFO_DEPTH = 4;
endpackage

// file: rtl/dsr_regs.sv
// Status, interrupt and output-port register bank on an AHB-Lite slave.
`timescale 1ns/1ps
module dsr_regs
  import dsr_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] rx_push,
  input wire logic [1:0][2:0] rx_push_flags,
  input wire logic [1:0] rx_pop,
  input wire logic [1:0] rx_reset,
  input wire logic [1:0] error_block_mode,
  input wire logic [1:0] rx_int_full_sel,
  input wire logic [1:0] overrun,
  input wire logic [1:0] transmitter_empty,
  input wire logic [1:0] transmit_ready,
  input wire logic [1:0] break_change,
  input wire logic counter_ready,
  input wire logic counter_out,
  input wire logic chan_a_transmit_clock_16x,
  input wire logic chan_a_transmit_clock,
  input wire logic chan_a_receive_clock,
  input wire logic chan_b_transmit_clock,
  input wire logic chan_b_receive_clock,
  input wire logic [3:0] input_pin,
  output logic [7:0] output_pin,
  output logic [1:0] fifo_full,
  output logic [1:0] receive_ready,
  output logic irq,
  output logic baud_set_sel,
  output logic [2:0] counter_mode,
  output logic [15:0] timer_preset
);
  // Queue pointers wrap by plain binary overflow, so the depth must be a power of two.
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo_depth
    $error("dsr_regs: FIFO_DEPTH must be a power of two, at least 2");
  end

  // All state apart from the error queues lives in one struct, so reset and hold are written once.
  typedef struct packed {
    logic [7:0] ocfg;
    logic [7:0] olatch;
    logic [7:0] aux;
    logic [7:0] interrupt_mask;
    logic [7:0] interrupt_status;
    logic [7:0] ctu;
    logic [7:0] ctl;
    logic [3:0] delta;
    logic [3:0] in_s1;
    logic [3:0] in_s2;
    logic [3:0] in_s3;
    logic [7:0] src_prev;
    logic [7:0] addr_r;
    logic wr_pend;
    logic rd_pend;
    logic [31:0] rdata;
    logic irq;
    logic [7:0] opin;
  } dsr_state_t;

  dsr_state_t s_reg;
  dsr_state_t s_next;

  logic [1:0][2:0] top_flags;
  logic [1:0] err_reset;
  logic [1:0] rx_sel;
  logic [1:0][7:0] line_status;
  logic [7:0] int_src;
  logic [7:0] int_set;
  logic [7:0] rd_byte;
  logic [3:0] in_change;
  logic accept;
  logic wr_now;

  // Bus write lands in the data phase, so the command decodes from hwdata here.
  assign wr_now = s_reg.wr_pend;
  // Only haddr[7:2] is decoded, so the map repeats every 256 bytes.
  assign accept = hsel && hready && htrans[1];

  // Each channel's bit of the command word clears that channel's queued flags.
  always_comb begin
    err_reset = 2'h0;
    if (wr_now && s_reg.addr_r == ADDR_ERROR_RESET_CMD) begin
      err_reset = hwdata[CMD_ERR_RESET_LSB +: 2];
    end
  end

  // One error queue per channel; they share no state, so resetting one spares the other.
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    dsr_err_fifo #(
      .DEPTH(FIFO_DEPTH)
    ) u_err_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .push(rx_push[ch]),
      .push_flags(rx_push_flags[ch]),
      .pop(rx_pop[ch]),
      .err_reset(err_reset[ch]),
      .rx_reset(rx_reset[ch]),
      .block_mode(error_block_mode[ch]),
      .top_flags(top_flags[ch]),
      .full(fifo_full[ch]),
      .not_empty(receive_ready[ch])
    );
    // Error flags from the queue sit above the live channel status.
    assign line_status[ch] = {top_flags[ch],
                              overrun[ch],
                              transmitter_empty[ch],
                              transmit_ready[ch],
                              fifo_full[ch],
                              receive_ready[ch]};
    assign rx_sel[ch] = rx_int_full_sel[ch] ? fifo_full[ch] : receive_ready[ch];
  end

  // Change flags only raise the input-port interrupt where enabled.
  assign in_change = s_reg.in_s2 ^ s_reg.in_s3;

  // Level sources of the interrupt status, bit 7 down to bit 0.
  assign int_src = {|(s_reg.delta & s_reg.aux[3:0]),
                    1'b0,
                    rx_sel[1],
                    transmit_ready[1],
                    1'b0,
                    1'b0,
                    rx_sel[0],
                    transmit_ready[0]};

  // Level sources set on their rising edge; break and counter events are pulses.
  always_comb begin
    int_set = int_src & ~s_reg.src_prev;
    int_set[6] = break_change[1];
    int_set[3] = counter_ready;
    int_set[2] = break_change[0];
  end

  // Unmapped offsets read as zero rather than aliasing a real register.
  always_comb begin
    case (s_reg.addr_r)
      ADDR_CHAN_A_LINE_STATUS: begin
        rd_byte = line_status[0];
      end
      ADDR_CHAN_B_LINE_STATUS: begin
        rd_byte = line_status[1];
      end
      ADDR_OUTPUT_PIN_SOURCE_CONFIG: begin
        rd_byte = s_reg.ocfg;
      end
      ADDR_OUTPUT_PIN_LATCH: begin
        rd_byte = s_reg.olatch;
      end
      ADDR_AUXILIARY_CONTROL: begin
        rd_byte = s_reg.aux;
      end
      ADDR_INPUT_CHANGE_STATUS: begin
        rd_byte = {s_reg.delta, s_reg.in_s2};
      end
      ADDR_INTERRUPT_STATUS: begin
        rd_byte = s_reg.interrupt_status;
      end
      ADDR_INTERRUPT_MASK: begin
        rd_byte = s_reg.interrupt_mask;
      end
      ADDR_TIMER_PRESET_UPPER: begin
        rd_byte = s_reg.ctu;
      end
      ADDR_TIMER_PRESET_LOWER: begin
        rd_byte = s_reg.ctl;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;

    // Input pins come from outside the clock domain.
    s_next.in_s1 = input_pin;
    s_next.in_s2 = s_reg.in_s1;
    s_next.in_s3 = s_reg.in_s2;

    // Bus address phase. A read waits one cycle so it sees a write landing now.
    s_next.wr_pend = 1'b0;
    s_next.rd_pend = 1'b0;
    if (accept) begin
      s_next.addr_r = {haddr[7:2], 2'b00};
      s_next.wr_pend = hwrite;
      s_next.rd_pend = !hwrite;
    end

    // Read capture; reading the input change register clears its change flags.
    if (s_reg.rd_pend) begin
      s_next.rdata = {24'h000000, rd_byte};
      if (s_reg.addr_r == ADDR_INPUT_CHANGE_STATUS) begin
        s_next.delta = 4'h0;
      end
      // Reading a status register does not pop the queue; popping is the receiver's job.
      if (s_reg.addr_r == ADDR_CHAN_A_LINE_STATUS) begin
        s_next.rdata = {24'h000000, line_status[0]};
      end
    end

    // Register writes in the data phase.
    if (wr_now) begin
      case (s_reg.addr_r)
        ADDR_OUTPUT_PIN_SOURCE_CONFIG: begin
          s_next.ocfg = hwdata[7:0];
        end
        ADDR_OUTPUT_PIN_LATCH: begin
          s_next.olatch = hwdata[7:0];
        end
        ADDR_AUXILIARY_CONTROL: begin
          s_next.aux = hwdata[7:0];
        end
        ADDR_INTERRUPT_STATUS: begin
          s_next.interrupt_status = s_reg.interrupt_status & ~hwdata[7:0];
        end
        ADDR_INTERRUPT_MASK: begin
          s_next.interrupt_mask = hwdata[7:0];
        end
        ADDR_TIMER_PRESET_UPPER: begin
          s_next.ctu = hwdata[7:0];
        end
        ADDR_TIMER_PRESET_LOWER: begin
          s_next.ctl = hwdata[7:0];
        end
        ADDR_CHAN_A_LINE_STATUS, ADDR_CHAN_B_LINE_STATUS, ADDR_INPUT_CHANGE_STATUS: begin
          // Status registers are read-only; a write to them changes nothing.
          s_next.ocfg = s_reg.ocfg;
        end
        default: begin
          s_next.ocfg = s_reg.ocfg;
        end
      endcase
    end

    // Change detection; a change in the clearing cycle is kept.
    s_next.delta = s_next.delta | in_change;

    // Sticky interrupt status; setting wins over a write-one clear.
    s_next.src_prev = int_src;
    s_next.interrupt_status = s_next.interrupt_status | int_set;
    // The request is registered from the next status and mask, so it changes in the same cycle as the status and never glitches.
    s_next.irq = |(s_next.interrupt_status & s_next.interrupt_mask);

    // Output pin sources before inversion.
    s_next.opin = s_next.olatch;
    if (s_next.ocfg[7]) begin
      s_next.opin[7] = transmit_ready[1];
    end
    if (s_next.ocfg[6]) begin
      s_next.opin[6] = transmit_ready[0];
    end
    if (s_next.ocfg[5]) begin
      s_next.opin[5] = rx_sel[1];
    end
    if (s_next.ocfg[4]) begin
      s_next.opin[4] = rx_sel[0];
    end
    case (s_next.ocfg[OCFG_PIN3_LSB +: 2])
      SRC_LATCH: begin
        s_next.opin[3] = s_next.olatch[3];
      end
      SRC_ALT1: begin
        s_next.opin[3] = counter_out;
      end
      SRC_ALT2: begin
        s_next.opin[3] = chan_b_transmit_clock;
      end
      default: begin
        s_next.opin[3] = chan_b_receive_clock;
      end
    endcase
    case (s_next.ocfg[OCFG_PIN2_LSB +: 2])
      SRC_LATCH: begin
        s_next.opin[2] = s_next.olatch[2];
      end
      SRC_ALT1: begin
        s_next.opin[2] = chan_a_transmit_clock_16x;
      end
      SRC_ALT2: begin
        s_next.opin[2] = chan_a_transmit_clock;
      end
      default: begin
        s_next.opin[2] = chan_a_receive_clock;
      end
    endcase
  end

  // Reset is synchronous and clears the pin sources, so the pins read high from then on.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ocfg <= REG_RESET;
      s_reg.olatch <= REG_RESET;
      s_reg.aux <= REG_RESET;
      s_reg.interrupt_mask <= REG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Inversion happens after the source mux, so routed signals come out inverted too.
  assign output_pin = ~s_reg.opin;
  // A read holds the bus one cycle so its data comes from a flop, not from the decode.
  assign hreadyout = !s_reg.rd_pend;
  // Every transfer completes with an OKAY response; no access is refused.
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign baud_set_sel = s_reg.aux[AUX_BAUD_SET_BIT];
  assign counter_mode = s_reg.aux[AUX_CT_MODE_LSB +: 3];
  assign timer_preset = {s_reg.ctu, s_reg.ctl};
endmodule // dsr_regs

// file: verif/dsr_regs_chk.sv
// Concurrent checks on the bus, FIFO status and pin ports of the register bank.
`timescale 1ns/1ps
module dsr_regs_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] rx_push,
  input wire logic [1:0] rx_pop,
  input wire logic [1:0] rx_reset,
  input wire logic [1:0] fifo_full,
  input wire logic [1:0] receive_ready,
  input wire logic [7:0] output_pin,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic taken;
  assign taken = hsel && hready && htrans[1];
  // One wait state per read keeps the registered read data aligned.
  sequence rd_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  read_wait_a: assert property (taken && !hwrite |=> rd_wait_s)
    else $error("read wait state wrong");
  write_ready_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  ready_rise_a: assert property ($rose(receive_ready[0]) |-> $past(rx_push[0]))
    else $error("receive ready rose without push");
  ready_fall_a: assert property ($fell(receive_ready[1]) |->
    $past(rx_pop[1] || rx_reset[1] || rst))
    else $error("receive ready fell without pop");
  full_ready_a: assert property (fifo_full[0] |-> receive_ready[0])
    else $error("full without ready");
  reset_pins_a: assert property ($fell(rst) |-> output_pin == 8'hFF && !irq)
    else $error("pins wrong after reset");
endmodule // dsr_regs_chk
bind dsr_regs dsr_regs_chk u_chk (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .rx_push(rx_push), .rx_pop(rx_pop), .rx_reset(rx_reset), .fifo_full(fifo_full),
  .receive_ready(receive_ready), .output_pin(output_pin), .irq(irq)
);

// file: verif/dsr_rx_model.sv
// Receive-side model that queues characters into the channel FIFOs.
`timescale 1ns/1ps
module dsr_rx_model (
  input wire logic core_clk,
  output logic [1:0] rx_push,
  output logic [1:0][2:0] rx_push_flags,
  output logic [1:0] rx_pop,
  output logic [1:0] rx_reset
);
  initial begin
    rx_push = 2'h0;
    rx_push_flags = '0;
    rx_pop = 2'h0;
    rx_reset = 2'h0;
  end
  // Flags are inverted once the strobe drops so stale values never look valid.
  task automatic push(input int ch, input logic [2:0] f);
    @(posedge core_clk);
    rx_push[ch] <= 1'b1;
    rx_push_flags[ch] <= f;
    @(posedge core_clk);
    rx_push[ch] <= 1'b0;
    rx_push_flags[ch] <= ~f;
  endtask
  task automatic strobe(input bit rr, input int ch);
    @(posedge core_clk);
    if (rr) rx_reset[ch] <= 1'b1;
    else rx_pop[ch] <= 1'b1;
    @(posedge core_clk);
    rx_reset[ch] <= 1'b0;
    rx_pop[ch] <= 1'b0;
  endtask
endmodule // dsr_rx_model

// file: verif/tb.sv
// Self-checking bench for the status, interrupt and output-port register bank.
`timescale 1ns/1ps
module tb;
  import dsr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hreadyout;
  logic hresp;
  logic [1:0] blk = 2'h0;
  logic [1:0] brk = 2'h0;
  logic [1:0] fsel = 2'h0;
  logic ctr = 1'b0;
  logic [5:0] src = 6'h0;
  logic [3:0] ip = 4'h0;
  logic [1:0] rx_push, rx_pop, rx_reset, fifo_full, receive_ready;
  logic [1:0][2:0] rx_push_flags;
  logic [7:0] output_pin;
  logic irq, baud_set_sel;
  logic [2:0] counter_mode;
  logic [15:0] timer_preset;
  int n_errors = 0;
  int tests_run = 0;
  always #10 core_clk = ~core_clk;
  dsr_rx_model u_rx (.core_clk(core_clk), .rx_push(rx_push), .rx_push_flags(rx_push_flags),
    .rx_pop(rx_pop), .rx_reset(rx_reset));
  dsr_regs DUT (.core_clk(core_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_push(rx_push),
    .rx_push_flags(rx_push_flags), .rx_pop(rx_pop), .rx_reset(rx_reset),
    .error_block_mode(blk), .rx_int_full_sel(fsel), .overrun(2'b01),
    .transmitter_empty(2'b11), .transmit_ready(2'b01), .break_change(brk),
    .counter_ready(ctr), .counter_out(src[0]), .chan_a_transmit_clock_16x(src[1]),
    .chan_a_transmit_clock(src[2]), .chan_a_receive_clock(src[3]),
    .chan_b_transmit_clock(src[4]), .chan_b_receive_clock(src[5]), .input_pin(ip),
    .output_pin(output_pin), .fifo_full(fifo_full), .receive_ready(receive_ready),
    .irq(irq), .baud_set_sel(baud_set_sel), .counter_mode(counter_mode),
    .timer_preset(timer_preset));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Outputs are read in the edge's own time step, so the value seen is the one that stood.
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic br(input logic [7:0] a, output logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    br(a, d);
    chk(n, e, d);
  endtask
  task automatic t_status();
    u_rx.push(0, 3'b101);
    u_rx.push(0, 3'b010);
    rc(ADDR_CHAN_A_LINE_STATUS, 32'hBD, "status a top");
    u_rx.strobe(0, 0);
    rc(ADDR_CHAN_A_LINE_STATUS, 32'h5D, "status a next");
    bw(ADDR_ERROR_RESET_CMD, 8'h01);
    rc(ADDR_CHAN_A_LINE_STATUS, 32'h1D, "status a cleared");
    repeat (3) u_rx.push(0, 3'b111);
    w(1);
    chk("fifo full", 32'h1, 32'(fifo_full));
    u_rx.strobe(1, 0);
    w(1);
    chk("rx ready", 32'h0, 32'(receive_ready));
    $display("status test done");
  endtask
  task automatic t_block();
    blk <= 2'b10;
    u_rx.push(1, 3'b100);
    u_rx.push(1, 3'b001);
    u_rx.strobe(0, 1);
    rc(ADDR_CHAN_B_LINE_STATUS, 32'hA9, "status b block");
    u_rx.strobe(0, 1);
    rc(ADDR_CHAN_B_LINE_STATUS, 32'hA8, "status b drained");
    bw(ADDR_ERROR_RESET_CMD, 8'h02);
    rc(ADDR_CHAN_B_LINE_STATUS, 32'h08, "status b cleared");
    $display("block test done");
  endtask
  task automatic t_pins();
    logic [1:0] e;
    u_rx.push(0, 3'b000);
    bw(ADDR_OUTPUT_PIN_LATCH, 8'hAB);
    for (int p = 0; p < 2; p++) begin
      src <= (p == 0) ? 6'b011001 : 6'b100110;
      for (int s = 0; s < 4; s++) begin
        bw(ADDR_OUTPUT_PIN_SOURCE_CONFIG, 8'(s * 5));
        w(2);
        case (s)
          0: e = 2'b10;
          1: e = {src[0], src[1]};
          2: e = {src[4], src[2]};
          default: e = {src[5], src[3]};
        endcase
        chk("pins sel", {24'h0, 4'h5, ~e, 2'b00}, 32'(output_pin));
      end
    end
    bw(ADDR_OUTPUT_PIN_SOURCE_CONFIG, 8'hF0);
    w(2);
    chk("pins status", 32'hA4, 32'(output_pin));
    fsel <= 2'b01;
    w(2);
    chk("pins full sel", 32'hB4, 32'(output_pin));
    fsel <= 2'b00;
    u_rx.strobe(0, 0);
    $display("pins test done");
  endtask
  task automatic t_irq();
    logic [31:0] d;
    bw(ADDR_INTERRUPT_STATUS, 8'hFF);
    bw(ADDR_INTERRUPT_MASK, 8'h08);
    ctr <= 1'b1;
    @(posedge core_clk);
    ctr <= 1'b0;
    w(3);
    chk("irq set", 32'h1, 32'(irq));
    brk <= 2'b11;
    @(posedge core_clk);
    brk <= 2'b00;
    br(ADDR_INTERRUPT_STATUS, d);
    chk("isr bits", 32'h4C, d);
    bw(ADDR_INTERRUPT_STATUS, 8'h08);
    w(2);
    chk("irq masked", 32'h0, 32'(irq));
    bw(ADDR_INTERRUPT_MASK, 8'h04);
    w(2);
    chk("irq unmasked", 32'h1, 32'(irq));
    $display("irq test done");
  endtask
  task automatic t_misc();
    logic [31:0] d;
    bw(ADDR_AUXILIARY_CONTROL, 8'hD2);
    bw(ADDR_TIMER_PRESET_UPPER, 8'h12);
    bw(ADDR_TIMER_PRESET_LOWER, 8'h34);
    w(1);
    chk("baud set", 32'h1, 32'(baud_set_sel));
    chk("ct mode", 32'h5, 32'(counter_mode));
    chk("preset", 32'h1234, 32'(timer_preset));
    rc(8'h3C, 32'h0, "unmapped");
    ip <= 4'h2;
    w(8);
    rc(ADDR_INPUT_CHANGE_STATUS, 32'h22, "ipc change");
    rc(ADDR_INPUT_CHANGE_STATUS, 32'h02, "ipc cleared");
    br(ADDR_INTERRUPT_STATUS, d);
    chk("isr input change", 32'h80, d & 32'h80);
    $display("misc test done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_status();
    t_block();
    t_pins();
    t_irq();
    t_misc();
    complete_run();
  end
endmodule // tb
